// [logic/seqnc_pkg.sv]
// seqnc_pkg: register map, field positions, reset values and error codes for the
// system error queue and network configuration block.
// assumes a 32-bit apb master and a single 40 mhz clock domain.
package seqnc_pkg;

  // apb byte offsets, one aligned word each
  localparam logic [7:0] SEQNC_OFF_ERR_COUNT = 8'h00;
  localparam logic [7:0] SEQNC_OFF_ERR_NEXT = 8'h04;
  localparam logic [7:0] SEQNC_OFF_EVT_STATUS = 8'h08;
  localparam logic [7:0] SEQNC_OFF_EVT_CLEAR = 8'h0c;
  localparam logic [7:0] SEQNC_OFF_EVT_ENABLE = 8'h10;
  localparam logic [7:0] SEQNC_OFF_SYS_CTRL = 8'h14;
  localparam logic [7:0] SEQNC_OFF_VERSION = 8'h18;
  localparam logic [7:0] SEQNC_OFF_STATIC_ADDR = 8'h1c;
  localparam logic [7:0] SEQNC_OFF_DHCP = 8'h20;
  localparam logic [7:0] SEQNC_OFF_GATEWAY = 8'h24;
  localparam logic [7:0] SEQNC_OFF_PORT = 8'h28;
  localparam logic [7:0] SEQNC_OFF_SUBNET = 8'h2c;
  localparam logic [7:0] SEQNC_OFF_HW_ADDR_OUI = 8'h30;
  localparam logic [7:0] SEQNC_OFF_HW_ADDR_SER = 8'h34;
  localparam logic [7:0] SEQNC_OFF_NET_SERIAL = 8'h38;
  localparam logic [7:0] SEQNC_OFF_NET_VERSION = 8'h3c;
  localparam logic [7:0] SEQNC_OFF_HOST_NAME0 = 8'h40;
  localparam logic [7:0] SEQNC_OFF_HOST_NAME3 = 8'h4c;
  localparam logic [7:0] SEQNC_OFF_FAULT = 8'h50;

  // error queue geometry
  localparam int unsigned SEQNC_QDEPTH = 8;
  localparam int unsigned SEQNC_QPTR_W = 3;
  localparam int unsigned SEQNC_QCNT_W = 4;

  // error codes, two's complement 16 bit
  localparam logic [15:0] SEQNC_ERR_NONE = 16'h0000;
  localparam logic [15:0] SEQNC_ERR_COMMAND = 16'hff9c;
  localparam logic [15:0] SEQNC_ERR_SYNTAX = 16'hff9a;
  localparam logic [15:0] SEQNC_ERR_TOO_MANY = 16'hff94;
  localparam logic [15:0] SEQNC_ERR_RANGE = 16'hff22;
  localparam logic [15:0] SEQNC_ERR_OVERFLOW = 16'hfea2;
  localparam logic [15:0] SEQNC_ERR_QUERY = 16'hfe70;

  // message identifiers returned beside each code
  localparam logic [7:0] SEQNC_MSG_NONE = 8'h00;
  localparam logic [7:0] SEQNC_MSG_COMMAND = 8'h01;
  localparam logic [7:0] SEQNC_MSG_SYNTAX = 8'h02;
  localparam logic [7:0] SEQNC_MSG_TOO_MANY = 8'h03;
  localparam logic [7:0] SEQNC_MSG_RANGE = 8'h04;
  localparam logic [7:0] SEQNC_MSG_OVERFLOW = 8'h05;
  localparam logic [7:0] SEQNC_MSG_QUERY = 8'h06;
  localparam logic [7:0] SEQNC_MSG_OTHER = 8'h07;

  // event status bit positions by error class
  localparam int unsigned SEQNC_EVT_CMD_BIT = 5;
  localparam int unsigned SEQNC_EVT_EXE_BIT = 4;
  localparam int unsigned SEQNC_EVT_DEV_BIT = 3;
  localparam int unsigned SEQNC_EVT_QRY_BIT = 2;
  localparam logic [5:0] SEQNC_EVT_MASK = 6'h3c;

  // field positions
  localparam int unsigned SEQNC_NEXT_MSG_LSB = 16;
  localparam int unsigned SEQNC_CTRL_RESTART_BIT = 0;

  // factory defaults
  localparam logic [31:0] SEQNC_RST_STATIC_ADDR = 32'hc0a8_0164;
  localparam logic [31:0] SEQNC_RST_GATEWAY = 32'hc0a8_0101;
  localparam logic [31:0] SEQNC_RST_SUBNET = 32'hffff_ff00;
  localparam logic [15:0] SEQNC_RST_PORT = 16'hc549;
  localparam logic SEQNC_RST_DHCP = 1'b0;

  // identity values, arbitrary
  localparam logic [7:0] SEQNC_BOOT_REV = 8'h01;
  localparam logic [7:0] SEQNC_FW_REV = 8'h02;
  localparam logic [7:0] SEQNC_HW_REV = 8'h03;
  localparam logic [23:0] SEQNC_HW_ADDR_OUI = 24'h00_1234;
  localparam logic [23:0] SEQNC_HW_ADDR_SER = 24'h00_0001;
  localparam logic [23:0] SEQNC_NET_SERIAL = 24'h00_0001;
  localparam logic [31:0] SEQNC_NET_VERSION = 32'h0001_0001;
  localparam logic [127:0] SEQNC_HOST_NAME = 128'h6465_7669_6365_3031_0000_0000_0000_0000;

endpackage : seqnc_pkg

// [logic/seqnc_top.sv]
// seqnc_top: apb slave holding the error queue, event status, restart control,
// version and network settings of the instrument's system command group.
// assumes a 32-bit apb master on clock; error reports and dhcp address are on-clock,
// the hard fault pin is asynchronous and is synchronised here.
//
// Summary of operation
// RL1 - error count register returns how many entries the queue holds
// RL2 - errors are kept first-in first-out and read oldest first
// RL3 - each next-error read removes the entry, count drops by one
// RL4 - next-error read on an empty queue returns code 0, no-error message
// RL5 - on overflow the final queue entry becomes code -350, excess errors discarded
// RL6 - next-error reply carries signed code plus its message identifier
// RL7 - logged errors set event bits 5,4,3,2 by command/execution/device/query class
// RL8 - codes used: -100, -102, -108, -222, -400
// RL9 - restart command restarts the system and clears latched hard faults
// RL10 - version register gives bootloader, firmware, hardware revisions in that order
// RL11 - static address holds four bytes, reads back, defaults 192.168.1.100
// RL12 - dhcp 1 takes the server address; dhcp 0 applies the static address
// RL13 - gateway holds four bytes, reads back, defaults 192.168.1.1
// RL14 - port is 16 bit, 1 to 65535, default 50505, 49151 not enforced
// RL15 - hardware address is six fixed read-only bytes, organisation id first
// RL16 - network module serial is a read-only value from 1 to 16777215
// RL17 - subnet mask holds four bytes, defaults 255.255.255.0
// RL18 - network version and host name are readable strings
// RL19 - queue depth is a parameter with one slot kept for overflow entry
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module seqnc_top
  import seqnc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic err_log_valid,
  input wire logic [15:0] err_log_code,
  output logic err_log_busy,
  input wire logic hard_fault_pin,
  input wire logic [31:0] dhcp_lease_addr,
  output logic hard_fault_latched,
  output logic sys_restart,
  output logic dhcp_enable,
  output logic [31:0] active_ip_addr,
  output logic [31:0] gateway_addr,
  output logic [31:0] subnet_mask,
  output logic [15:0] socket_port,
  output logic irq
);

  // event class of an error code, one bit per class
  function automatic logic [5:0] seqnc_class(input logic [15:0] code);
    logic signed [15:0] c;
    logic [5:0] m;
    c = code;
    m = 6'h00;
    if (c <= -16'sd100 && c >= -16'sd199) begin
      m[SEQNC_EVT_CMD_BIT] = 1'b1;
    end else if (c <= -16'sd200 && c >= -16'sd299) begin
      m[SEQNC_EVT_EXE_BIT] = 1'b1;
    end else if (c <= -16'sd300 && c >= -16'sd399) begin
      m[SEQNC_EVT_DEV_BIT] = 1'b1;
    end else if (c <= -16'sd400 && c >= -16'sd499) begin
      m[SEQNC_EVT_QRY_BIT] = 1'b1;
    end
    return m;
  endfunction : seqnc_class

  // message identifier that travels beside a code
  function automatic logic [7:0] seqnc_msg(input logic [15:0] code);
    logic [7:0] m;
    unique case (code)
      SEQNC_ERR_NONE: m = SEQNC_MSG_NONE;
      SEQNC_ERR_COMMAND: m = SEQNC_MSG_COMMAND;
      SEQNC_ERR_SYNTAX: m = SEQNC_MSG_SYNTAX;
      SEQNC_ERR_TOO_MANY: m = SEQNC_MSG_TOO_MANY;
      SEQNC_ERR_RANGE: m = SEQNC_MSG_RANGE;
      SEQNC_ERR_OVERFLOW: m = SEQNC_MSG_OVERFLOW;
      SEQNC_ERR_QUERY: m = SEQNC_MSG_QUERY;
      default: m = SEQNC_MSG_OTHER;
    endcase
    return m;
  endfunction : seqnc_msg

  logic [15:0] queue_mem [SEQNC_QDEPTH];
  logic [SEQNC_QPTR_W-1:0] rd_ptr_ff;
  logic [SEQNC_QPTR_W-1:0] wr_ptr_ff;
  logic [SEQNC_QCNT_W-1:0] count_ff;
  logic [5:0] evt_status_ff;
  logic [5:0] evt_enable_ff;
  logic [31:0] static_addr_ff;
  logic [31:0] gateway_ff;
  logic [31:0] subnet_ff;
  logic [15:0] port_ff;
  logic dhcp_ff;
  logic [15:0] pend_code_ff;
  logic pend_valid_ff;
  logic fault_meta_ff;
  logic fault_sync_ff;
  logic fault_latch_ff;
  logic restart_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  logic [31:0] active_ip_ff;

  logic access_done;
  logic wr_done;
  logic rd_done;
  logic addr_known;
  logic addr_ro;
  logic pop;
  logic push;
  logic [15:0] push_code;
  logic store_ok;
  logic [15:0] store_code;
  logic pop_armed_ff;
  logic [15:0] nxt_pend_code;
  logic nxt_pend_valid;
  logic [31:0] nxt_prdata;

  // the transfer completes at the edge where the master sees pready high
  assign access_done = psel & penable & pready_ff;
  assign wr_done = access_done & pwrite;
  assign rd_done = access_done & ~pwrite;

  // address decode; host name spans four words
  always_comb begin
    addr_known = 1'b1;
    addr_ro = 1'b0;
    unique case (paddr)
      SEQNC_OFF_ERR_COUNT, SEQNC_OFF_ERR_NEXT, SEQNC_OFF_EVT_STATUS, SEQNC_OFF_VERSION,
      SEQNC_OFF_HW_ADDR_OUI, SEQNC_OFF_HW_ADDR_SER, SEQNC_OFF_NET_SERIAL, SEQNC_OFF_NET_VERSION,
      SEQNC_OFF_FAULT: addr_ro = 1'b1;
      SEQNC_OFF_EVT_CLEAR, SEQNC_OFF_EVT_ENABLE, SEQNC_OFF_SYS_CTRL, SEQNC_OFF_STATIC_ADDR,
      SEQNC_OFF_DHCP, SEQNC_OFF_GATEWAY, SEQNC_OFF_PORT, SEQNC_OFF_SUBNET: addr_ro = 1'b0;
      default: begin
        addr_known = (paddr >= SEQNC_OFF_HOST_NAME0) && (paddr <= SEQNC_OFF_HOST_NAME3) && (paddr[1:0] == 2'b00);
        addr_ro = addr_known;
      end
    endcase
  end

  // read data mux, sampled one cycle before the transfer completes
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      SEQNC_OFF_ERR_COUNT: nxt_prdata = {28'h000_0000, count_ff}; // [RL1]
      SEQNC_OFF_ERR_NEXT: begin
        if (count_ff == '0) begin
          nxt_prdata = {8'h00, SEQNC_MSG_NONE, SEQNC_ERR_NONE}; // [RL4]
        end else begin
          nxt_prdata = {8'h00, seqnc_msg(queue_mem[rd_ptr_ff]), queue_mem[rd_ptr_ff]}; // [RL2] [RL6]
        end
      end
      SEQNC_OFF_EVT_STATUS: nxt_prdata = {26'h000_0000, evt_status_ff};
      SEQNC_OFF_EVT_ENABLE: nxt_prdata = {26'h000_0000, evt_enable_ff};
      SEQNC_OFF_VERSION: nxt_prdata = {8'h00, SEQNC_BOOT_REV, SEQNC_FW_REV, SEQNC_HW_REV}; // [RL10]
      SEQNC_OFF_STATIC_ADDR: nxt_prdata = static_addr_ff; // [RL11]
      SEQNC_OFF_DHCP: nxt_prdata = {31'h0000_0000, dhcp_ff};
      SEQNC_OFF_GATEWAY: nxt_prdata = gateway_ff; // [RL13]
      SEQNC_OFF_PORT: nxt_prdata = {16'h0000, port_ff};
      SEQNC_OFF_SUBNET: nxt_prdata = subnet_ff; // [RL17]
      SEQNC_OFF_HW_ADDR_OUI: nxt_prdata = {8'h00, SEQNC_HW_ADDR_OUI}; // [RL15]
      SEQNC_OFF_HW_ADDR_SER: nxt_prdata = {8'h00, SEQNC_HW_ADDR_SER}; // [RL15]
      SEQNC_OFF_NET_SERIAL: nxt_prdata = {8'h00, SEQNC_NET_SERIAL}; // [RL16]
      SEQNC_OFF_NET_VERSION: nxt_prdata = SEQNC_NET_VERSION; // [RL18]
      SEQNC_OFF_FAULT: nxt_prdata = {31'h0000_0000, fault_latch_ff};
      default: begin
        if (addr_known) begin
          // host name word 0 holds the first four characters
          nxt_prdata = SEQNC_HOST_NAME[(32'd127 - 32'd32 * paddr[3:2]) -: 32]; // [RL18]
        end
      end
    endcase
  end

  // apb handshake: one wait state, so every access phase lasts two cycles
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pop_armed_ff <= 1'b0;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      // pop only what was captured, so an error landing mid-read is never lost
      pop_armed_ff <= psel & penable & ~pready_ff & ~pwrite & (paddr == SEQNC_OFF_ERR_NEXT) & (count_ff != '0);
      pslverr_ff <= psel & penable & ~pready_ff & (~addr_known | (pwrite & addr_ro));
      if (psel & penable & ~pready_ff & ~pwrite) begin
        prdata_ff <= nxt_prdata;
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // bus faults become queue entries: unknown address is a syntax error, a write to a
  // read-only word has too many parameters, a zero port is out of range
  always_comb begin
    nxt_pend_valid = 1'b0;
    nxt_pend_code = pend_code_ff;
    if (access_done && !addr_known) begin
      nxt_pend_valid = 1'b1;
      nxt_pend_code = SEQNC_ERR_SYNTAX; // [RL8]
    end else if (wr_done && addr_ro) begin
      nxt_pend_valid = 1'b1;
      nxt_pend_code = SEQNC_ERR_TOO_MANY; // [RL8]
    end else if (wr_done && paddr == SEQNC_OFF_PORT && pwdata[15:0] == 16'h0000) begin
      nxt_pend_valid = 1'b1;
      nxt_pend_code = SEQNC_ERR_RANGE; // [RL8] [RL14]
    end
  end

  // internal errors are held one cycle; the busy flag holds off external reports then
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_valid_ff <= 1'b0;
      pend_code_ff <= 16'h0000;
    end else begin
      pend_valid_ff <= nxt_pend_valid;
      pend_code_ff <= nxt_pend_code;
    end
  end

  assign push = pend_valid_ff | err_log_valid;
  assign push_code = pend_valid_ff ? pend_code_ff : err_log_code;
  assign pop = rd_done & pop_armed_ff;
  // the final free slot takes the overflow code; a full queue stores nothing
  assign store_ok = push & (count_ff < SEQNC_QCNT_W'(SEQNC_QDEPTH));
  assign store_code = (count_ff == SEQNC_QCNT_W'(SEQNC_QDEPTH - 1) && !pop) ? SEQNC_ERR_OVERFLOW : push_code;

  // fifo: the last slot is kept for the overflow code, so one real error fewer fits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff <= '0;
    end else if (restart_ff) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (store_ok) begin
        queue_mem[wr_ptr_ff] <= store_code; // [RL2] [RL5] [RL19]
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1; // [RL3]
      end
      // a full queue discards new errors until software reads some out
      if (store_ok && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !store_ok) begin
        count_ff <= count_ff - 1'b1; // [RL3]
      end
    end
  end

  // sticky event bits by error class; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evt_status_ff <= 6'h00;
    end else begin
      evt_status_ff <= (evt_status_ff & ~((wr_done && paddr == SEQNC_OFF_EVT_CLEAR) ? pwdata[5:0] : 6'h00))
                       | (store_ok ? seqnc_class(store_code) : 6'h00); // [RL7]
    end
  end

  // interrupt enable and level output
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evt_enable_ff <= 6'h00;
      irq_ff <= 1'b0;
    end else begin
      if (wr_done && paddr == SEQNC_OFF_EVT_ENABLE) begin
        evt_enable_ff <= pwdata[5:0] & SEQNC_EVT_MASK;
      end
      irq_ff <= |(evt_status_ff & evt_enable_ff);
    end
  end

  // network settings; port zero is refused and keeps the old value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      static_addr_ff <= SEQNC_RST_STATIC_ADDR;
      gateway_ff <= SEQNC_RST_GATEWAY;
      subnet_ff <= SEQNC_RST_SUBNET;
      port_ff <= SEQNC_RST_PORT;
      dhcp_ff <= SEQNC_RST_DHCP;
    end else if (wr_done) begin
      unique case (paddr)
        SEQNC_OFF_STATIC_ADDR: static_addr_ff <= pwdata; // [RL11]
        SEQNC_OFF_GATEWAY: gateway_ff <= pwdata; // [RL13]
        SEQNC_OFF_SUBNET: subnet_ff <= pwdata; // [RL17]
        SEQNC_OFF_DHCP: dhcp_ff <= pwdata[0];
        SEQNC_OFF_PORT: begin
          if (pwdata[15:0] != 16'h0000) begin
            port_ff <= pwdata[15:0]; // [RL14]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // address in use follows the dhcp mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      active_ip_ff <= SEQNC_RST_STATIC_ADDR;
    end else begin
      active_ip_ff <= dhcp_ff ? dhcp_lease_addr : static_addr_ff; // [RL12]
    end
  end

  // hard fault pin synchroniser and latch; restart is a one-cycle pulse
  // a fault still present at restart wins, so a live fault is never hidden
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault_meta_ff <= 1'b0;
      fault_sync_ff <= 1'b0;
      fault_latch_ff <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      fault_meta_ff <= hard_fault_pin;
      fault_sync_ff <= fault_meta_ff;
      restart_ff <= wr_done & (paddr == SEQNC_OFF_SYS_CTRL) & pwdata[SEQNC_CTRL_RESTART_BIT]; // [RL9]
      if (fault_sync_ff) begin
        fault_latch_ff <= 1'b1;
      end else if (restart_ff) begin
        fault_latch_ff <= 1'b0; // [RL9]
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign err_log_busy = pend_valid_ff;
  assign hard_fault_latched = fault_latch_ff;
  assign sys_restart = restart_ff;
  assign dhcp_enable = dhcp_ff;
  assign active_ip_addr = active_ip_ff;
  assign gateway_addr = gateway_ff;
  assign subnet_mask = subnet_ff;
  assign socket_port = port_ff;
  assign irq = irq_ff;

endmodule : seqnc_top

`default_nettype wire

// [testbench/seqnc_chk.sv]
// seqnc_chk: port-level assertions on apb timing, restart, fault latch and config outputs.
// assumes binding onto seqnc_top, one clock, active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module seqnc_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hard_fault_pin,
  input wire logic [31:0] dhcp_lease_addr,
  input wire logic hard_fault_latched,
  input wire logic sys_restart,
  input wire logic dhcp_enable,
  input wire logic [31:0] active_ip_addr,
  input wire logic [15:0] socket_port
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // exactly one wait state, answer is a single-cycle pulse
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // read data is zero outside the answer cycle so stale words never leak
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata nonzero outside answer");
  a_port_legal: assert property (socket_port != 16'h0000)
    else $error("socket port became zero");
  a_restart_pulse: assert property (sys_restart |=> !sys_restart)
    else $error("restart pulse too long");
  a_fault_sticky: assert property (hard_fault_latched |=> hard_fault_latched || sys_restart || $past(sys_restart))
    else $error("fault latch dropped without restart");
  a_restart_clears: assert property (!hard_fault_pin [*3] ##0 sys_restart |=> !hard_fault_latched)
    else $error("restart left fault latched");
  // synchroniser plus latch must settle within five samples
  a_fault_catch: assert property (hard_fault_pin [*5] |-> hard_fault_latched || sys_restart || $past(sys_restart))
    else $error("fault pin not latched");
  a_dhcp_follow: assert property (dhcp_enable && $past(dhcp_enable) |-> active_ip_addr == $past(dhcp_lease_addr))
    else $error("active address not from lease");
endmodule : seqnc_chk
bind seqnc_top seqnc_chk i_seqnc_chk (.clock, .rst_b, .psel, .penable, .prdata, .pready, .pslverr,
  .hard_fault_pin, .dhcp_lease_addr, .hard_fault_latched, .sys_restart, .dhcp_enable, .active_ip_addr,
  .socket_port);
`default_nettype wire

// [testbench/seqnc_far.sv]
// seqnc_far: error reporter, fault pin and dhcp server standing beside the block.
// assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module seqnc_far #(
  parameter logic [31:0] LEASE = 32'h0a00_0063
) (
  input wire logic clock,
  input wire logic err_log_busy,
  output logic err_log_valid,
  output logic [15:0] err_log_code,
  output logic hard_fault_pin,
  output logic [31:0] dhcp_lease_addr
);
  // quiet at time zero
  initial begin
    err_log_valid = 1'b0;
    err_log_code = 16'h0000;
    hard_fault_pin = 1'b0;
    dhcp_lease_addr = LEASE;
  end
  // hold the report until an edge sees busy low, then scramble the code
  task report(input logic [15:0] c);
    int n;
    @(posedge clock);
    err_log_valid <= 1'b1;
    err_log_code <= c;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (err_log_busy !== 1'b0 && n < 20);
    if (err_log_busy !== 1'b0) begin
      tb.chk(32'(err_log_busy), 32'h0);
      tb.print_verdict();
    end
    err_log_valid <= 1'b0;
    err_log_code <= ~c;
  endtask : report
  task fault(input logic v);
    @(posedge clock);
    hard_fault_pin <= v;
  endtask : fault
endmodule : seqnc_far
`default_nettype wire

// [testbench/tb.sv]
// tb: directed scenarios for the error queue, events, restart and network settings.
// assumes seqnc_top on apb with one wait state and seqnc_far driving the side inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import seqnc_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, active_ip_addr, gateway_addr, subnet_mask, dhcp_lease_addr, rdv;
  logic [15:0] socket_port, err_log_code;
  logic pready, pslverr, err_log_busy, hard_fault_latched, sys_restart, dhcp_enable, irq;
  logic err_log_valid, hard_fault_pin, err;
  int bad_count = 0;
  int samples_checked = 0;
  int restarts = 0;
  // code, message id and event bit of each listed error
  logic [15:0] codes [5] = '{16'hff9c, 16'hff9a, 16'hff94, 16'hff22, 16'hfe70};
  logic [7:0] ids [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
  int bits [5] = '{5, 5, 5, 4, 2};
  seqnc_top i_seqnc_top (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .err_log_valid, .err_log_code, .err_log_busy, .hard_fault_pin, .dhcp_lease_addr,
    .hard_fault_latched, .sys_restart, .dhcp_enable, .active_ip_addr, .gateway_addr, .subnet_mask,
    .socket_port, .irq);
  seqnc_far i_seqnc_far (.clock, .err_log_busy, .err_log_valid, .err_log_code, .hard_fault_pin,
    .dhcp_lease_addr);
  always #12.5 clock = ~clock;
  // count restart pulses, the pulse is too short to poll from a task
  always @(posedge clock) if (sys_restart === 1'b1) restarts <= restarts + 1;
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, an idle edge after it so the next setup never overlaps
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t no pready", $time);
      print_verdict();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, e);
  endtask : rd
  task pop(input logic [15:0] c, input logic [7:0] m);
    rd(SEQNC_OFF_ERR_NEXT, {8'h00, m, c});
  endtask : pop
  task t_defaults;
    rd(SEQNC_OFF_STATIC_ADDR, 32'hc0a8_0164);
    rd(SEQNC_OFF_GATEWAY, 32'hc0a8_0101);
    rd(SEQNC_OFF_SUBNET, 32'hffff_ff00);
    rd(SEQNC_OFF_PORT, 32'h0000_c549);
    rd(SEQNC_OFF_DHCP, 32'h0000_0000);
    chk(active_ip_addr, 32'hc0a8_0164);
    rd(SEQNC_OFF_ERR_COUNT, 32'h0000_0000);
    $display("test defaults done");
  endtask : t_defaults
  // read-only identity words; refused write and unmapped read log their codes
  task t_ident;
    rd(SEQNC_OFF_VERSION, {8'h00, SEQNC_BOOT_REV, SEQNC_FW_REV, SEQNC_HW_REV});
    rd(SEQNC_OFF_HW_ADDR_SER, {8'h00, SEQNC_HW_ADDR_SER});
    rd(SEQNC_OFF_NET_SERIAL, {8'h00, SEQNC_NET_SERIAL});
    rd(SEQNC_OFF_NET_VERSION, SEQNC_NET_VERSION);
    rd(SEQNC_OFF_HOST_NAME0, SEQNC_HOST_NAME[127:96]);
    wr(SEQNC_OFF_HW_ADDR_OUI, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    rd(SEQNC_OFF_HW_ADDR_OUI, {8'h00, SEQNC_HW_ADDR_OUI});
    pop(16'hff94, 8'h03);
    rd(8'h7c, 32'h0000_0000);
    chk(32'(err), 32'h1);
    pop(16'hff9a, 8'h02);
    $display("test ident done");
  endtask : t_ident
  task t_queue;
    wr(SEQNC_OFF_EVT_ENABLE, 32'h0000_0010);
    rd(SEQNC_OFF_ERR_NEXT, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(SEQNC_OFF_EVT_CLEAR, 32'h0000_003c);
      i_seqnc_far.report(codes[i]);
      rd(SEQNC_OFF_EVT_STATUS, 32'h1 << bits[i]);
      chk(32'(irq), 32'(bits[i] == 4));
    end
    rd(SEQNC_OFF_ERR_COUNT, 32'h0000_0005);
    for (int i = 0; i < 5; i++) begin
      pop(codes[i], ids[i]);
      rd(SEQNC_OFF_ERR_COUNT, 32'(4 - i));
    end
    rd(SEQNC_OFF_ERR_NEXT, 32'h0000_0000);
    $display("test queue done");
  endtask : t_queue
  // nine reports into eight slots, the last kept slot turns into overflow
  task t_overflow;
    for (int i = 0; i < 9; i++) i_seqnc_far.report(codes[i % 5]);
    rd(SEQNC_OFF_ERR_COUNT, 32'h0000_0008);
    for (int i = 0; i < 7; i++) pop(codes[i % 5], ids[i % 5]);
    pop(16'hfea2, 8'h05);
    rd(SEQNC_OFF_ERR_NEXT, 32'h0000_0000);
    rd(SEQNC_OFF_EVT_STATUS, 32'h0000_003c);
    wr(SEQNC_OFF_EVT_CLEAR, 32'h0000_003c);
    $display("test overflow done");
  endtask : t_overflow
  task t_net;
    wr(SEQNC_OFF_STATIC_ADDR, 32'h0a00_0002);
    rd(SEQNC_OFF_STATIC_ADDR, 32'h0a00_0002);
    chk(active_ip_addr, 32'h0a00_0002);
    wr(SEQNC_OFF_GATEWAY, 32'hc0a8_0afe);
    rd(SEQNC_OFF_GATEWAY, 32'hc0a8_0afe);
    chk(gateway_addr, 32'hc0a8_0afe);
    wr(SEQNC_OFF_SUBNET, 32'hffff_0000);
    rd(SEQNC_OFF_SUBNET, 32'hffff_0000);
    chk(subnet_mask, 32'hffff_0000);
    wr(SEQNC_OFF_PORT, 32'h0000_ffff);
    rd(SEQNC_OFF_PORT, 32'h0000_ffff);
    chk(32'(socket_port), 32'h0000_ffff);
    wr(SEQNC_OFF_PORT, 32'h0000_0000);
    chk(32'(err), 32'h0);
    rd(SEQNC_OFF_PORT, 32'h0000_ffff);
    pop(16'hff22, 8'h04);
    wr(SEQNC_OFF_DHCP, 32'h0000_0001);
    chk(32'(dhcp_enable), 32'h1);
    repeat (2) @(posedge clock);
    chk(active_ip_addr, 32'h0a00_0063);
    wr(SEQNC_OFF_DHCP, 32'h0000_0000);
    repeat (2) @(posedge clock);
    chk(active_ip_addr, 32'h0a00_0002);
    $display("test net done");
  endtask : t_net
  // fault latches, survives pin release, restart clears it and the queue
  task t_restart;
    i_seqnc_far.report(16'hff9c);
    i_seqnc_far.fault(1'b1);
    repeat (6) @(posedge clock);
    i_seqnc_far.fault(1'b0);
    repeat (4) @(posedge clock);
    chk(32'(hard_fault_latched), 32'h1);
    rd(SEQNC_OFF_FAULT, 32'h0000_0001);
    wr(SEQNC_OFF_SYS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk(32'(restarts), 32'h1);
    chk(32'(hard_fault_latched), 32'h0);
    rd(SEQNC_OFF_ERR_COUNT, 32'h0000_0000);
    $display("test restart done");
  endtask : t_restart
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_defaults();
    t_ident();
    t_queue();
    t_overflow();
    t_net();
    t_restart();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
